// ===== design/cis_pkg.sv
// Constants and carrier types for the interrupt sequencer
`default_nettype none
package cis_pkg;
  localparam int unsigned CIS_NSRC = 8;
  localparam int unsigned CIS_PC_W = 13;
  localparam int unsigned CIS_SP_W = 16;
  localparam int unsigned CIS_AW   = 3;
  // Register offsets
  localparam logic [2:0] CIS_A_STATUS = 3'h0;
  localparam logic [2:0] CIS_A_GENERAL_IRQ_CONTROL_REG   = 3'h1;
  localparam logic [2:0] CIS_A_ENABLE = 3'h2;
  localparam logic [2:0] CIS_A_FLAGS  = 3'h3;
  localparam logic [2:0] CIS_A_SPL    = 3'h4;
  localparam logic [2:0] CIS_A_SPH    = 3'h5;
  // Field positions
  localparam int unsigned CIS_GIE_BIT  = 7;
  localparam int unsigned CIS_VSEL_BIT = 1;
  // Reset values
  localparam logic [7:0]  CIS_STATUS_RST = 8'h00;
  localparam logic [15:0] CIS_SP_RST     = 16'h0000;
  localparam logic [12:0] CIS_APP_VEC    = 13'h0000;
  localparam logic [12:0] CIS_VEC_STEP   = 13'h0002;
  // Cycle counts at 100 MHz
  localparam logic [1:0] CIS_ENTRY_LAST = 2'h2;
  localparam logic [1:0] CIS_WAKE_LAST  = 2'h3;
  localparam logic [1:0] CIS_JUMP_LAST  = 2'h2;
  localparam logic [1:0] CIS_RET_LAST   = 2'h2;
  localparam logic [15:0] CIS_SP_STEP   = 16'h0001;

  typedef enum logic [2:0] {
    CIS_RUN   = 3'h0,
    CIS_WAKE  = 3'h1,
    CIS_ENTRY = 3'h2,
    CIS_JUMP  = 3'h3,
    CIS_RET   = 3'h4
  } cis_state_t;

  // Stack access toward data memory
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } cis_mem_req_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [2:0]  addr;
    logic [7:0]  wdata;
  } cis_reg_req_t;
endpackage
`default_nettype wire

// ===== design/cis_irq_seq.sv
// Interrupt sequencer: vectors, priority, enables, entry and return
//
// Summary of operation
// - Reset and each source get distinct vectors
// - Take only if source and global enabled
// - Vectors default to lowest program addresses
// - Lowest vector address wins, reset highest
// - Vector select moves vectors to boot start
// - Boot reset fuse moves reset vector
// - Boot lock settings suppress interrupts by PC
// - Entry clears global enable; nesting by software
// - Return instruction sets global enable
// - Flag cleared by hardware on vectoring
// - Writing one clears flag, zero ignored
// - Flags stay pending until enabled or cleared
// - Level sources request only while present
// - One main instruction after return first
// - Clear-enable instruction blocks same-cycle interrupt
// - Instruction after set-enable runs first
// - Entry four cycles, pushing program counter
// - Vector jump completes in three cycles
// - Multi-cycle instruction finishes before entry
// - Wake from sleep adds four cycles
// - Return four cycles, pops PC, SP plus two
// - Program counter thirteen bits, 8K words
// - Global enable is status bit seven
// - Entry push lowers stack pointer by two
`default_nettype none
module cis_irq_seq #(
  parameter logic [12:0] BOOT_START = 13'h1C00,
  parameter logic [7:0]  LVL_MASK   = 8'h00
) (
  input  wire logic                 clk,
  input  wire logic                 reset,
  input  wire logic                 clk_en,
  input  wire cis_pkg::cis_reg_req_t reg_req,
  output logic [7:0]                reg_rdata_q,
  input  wire logic [7:0]           evt_pulse,
  input  wire logic [7:0]           lvl_req,
  input  wire logic                 instr_boundary,
  input  wire logic                 instr_sei,
  input  wire logic                 instr_cli,
  input  wire logic                 instr_return_from_irq_instr,
  input  wire logic                 sleeping,
  input  wire logic [12:0]          program_counter,
  input  wire logic                 boot_reset_fuse,
  input  wire logic                 app_boot_lock_setting,
  input  wire logic                 boot_section_lock_setting,
  input  wire logic [7:0]           mem_rdata,
  output cis_pkg::cis_mem_req_t     mem_q,
  output logic                      busy_q,
  output logic                      vec_valid_q,
  output logic [12:0]               vec_addr_q,
  output logic [7:0]                ack_q,
  output logic                      resume_valid_q,
  output logic [12:0]               resume_pc_q,
  output logic [12:0]               reset_vec_q
);

  cis_pkg::cis_state_t state_q;
  logic [1:0]          cnt_q;
  logic [7:0]          status_q;
  logic                vector_select_bit;
  logic [7:0]          general_irq_control_reg;
  logic [7:0]          enable_q;
  logic [7:0]          flag_q;
  logic [15:0]         sp_q;
  logic [12:0]         ret_pc_q;
  logic [7:0]          pop_hi_q;
  logic [7:0]          sel_q;
  logic                block_q;
  logic [7:0]          pend;
  logic [7:0]          sel_oh;
  logic [12:0]         sel_vec;
  logic                gie;
  logic                lock_sup;
  logic                at_point;
  logic                take;
  logic                return_from_irq_instr_go;
  logic                wr_status;
  logic                wr_flags;
  logic [12:0]         vec_base;

  assign gie = status_q[cis_pkg::CIS_GIE_BIT];
  assign vector_select_bit = general_irq_control_reg[cis_pkg::CIS_VSEL_BIT];
  assign wr_status = reg_req.wr && reg_req.addr == cis_pkg::CIS_A_STATUS;
  assign wr_flags  = reg_req.wr && reg_req.addr == cis_pkg::CIS_A_FLAGS;

  // Event sources latch a flag; level sources bypass it
  genvar gi;
  generate
    for (gi = 0; gi < cis_pkg::CIS_NSRC; gi++)
    begin : g_src
      always_ff @(posedge clk or posedge reset)
      begin
        if (reset)
          flag_q[gi] <= 1'b0;
        else if (clk_en)
        begin
          // Set beats both clears so no event is lost
          if (evt_pulse[gi] && !LVL_MASK[gi])
            flag_q[gi] <= 1'b1;
          else if (wr_flags && reg_req.wdata[gi])
            flag_q[gi] <= 1'b0;
          else if (take && sel_oh[gi])
            flag_q[gi] <= 1'b0;
        end
      end
      // Level request is gone once its condition drops
      assign pend[gi] = (LVL_MASK[gi] ? lvl_req[gi] : flag_q[gi])
                        && enable_q[gi];
    end
  endgenerate

  // Lowest index has the lowest vector address
  always_comb
  begin
    sel_oh = 8'h00;
    for (int i = cis_pkg::CIS_NSRC - 1; i >= 0; i--)
    begin
      if (pend[i])
        sel_oh = 8'h01 << i;
    end
  end

  // Relocatable table; slot 0 belongs to reset
  assign vec_base = vector_select_bit ? BOOT_START : cis_pkg::CIS_APP_VEC;
  always_comb
  begin
    sel_vec = vec_base;
    for (int i = cis_pkg::CIS_NSRC - 1; i >= 0; i--)
    begin
      if (pend[i])
        sel_vec = vec_base + 13'(cis_pkg::CIS_VEC_STEP * 13'(i + 1));
    end
  end

  // Protected section runs without interrupts it cannot vet
  assign lock_sup = (app_boot_lock_setting && program_counter < BOOT_START
                     && vector_select_bit)
                 || (boot_section_lock_setting && program_counter >= BOOT_START
                     && !vector_select_bit);

  // Pipeline asserts the boundary only after multi-cycle ops end
  assign at_point = instr_boundary || sleeping;

  // Clear-enable in the same cycle wins over any request
  assign take = state_q == cis_pkg::CIS_RUN && at_point && gie
             && !instr_cli && !block_q && !lock_sup && !instr_return_from_irq_instr
             && |pend;
  assign return_from_irq_instr_go = state_q == cis_pkg::CIS_RUN && instr_boundary && instr_return_from_irq_instr;

  // Sequencer state
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state_q <= cis_pkg::CIS_RUN;
      cnt_q   <= 2'h0;
    end
    else if (clk_en)
    begin
      unique case (state_q)
        cis_pkg::CIS_RUN:
        begin
          cnt_q <= 2'h0;
          if (take)
            state_q <= sleeping ? cis_pkg::CIS_WAKE : cis_pkg::CIS_ENTRY;
          else if (return_from_irq_instr_go)
            state_q <= cis_pkg::CIS_RET;
        end
        cis_pkg::CIS_WAKE:
        begin
          // Extra cycles on top of oscillator start-up
          if (cnt_q == cis_pkg::CIS_WAKE_LAST)
          begin
            state_q <= cis_pkg::CIS_ENTRY;
            cnt_q   <= 2'h0;
          end
          else
            cnt_q <= cnt_q + 2'h1;
        end
        cis_pkg::CIS_ENTRY:
        begin
          if (cnt_q == cis_pkg::CIS_ENTRY_LAST)
          begin
            state_q <= cis_pkg::CIS_JUMP;
            cnt_q   <= 2'h0;
          end
          else
            cnt_q <= cnt_q + 2'h1;
        end
        cis_pkg::CIS_JUMP:
        begin
          if (cnt_q == cis_pkg::CIS_JUMP_LAST)
            state_q <= cis_pkg::CIS_RUN;
          else
            cnt_q <= cnt_q + 2'h1;
        end
        cis_pkg::CIS_RET:
        begin
          if (cnt_q == cis_pkg::CIS_RET_LAST)
            state_q <= cis_pkg::CIS_RUN;
          else
            cnt_q <= cnt_q + 2'h1;
        end
        default:
          state_q <= cis_pkg::CIS_RUN;
      endcase
    end
  end

  // Global enable; status bits other than it are software's to keep
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      status_q <= cis_pkg::CIS_STATUS_RST;
    else if (clk_en)
    begin
      if (take)
        status_q[cis_pkg::CIS_GIE_BIT] <= 1'b0;
      else if (instr_cli)
        status_q[cis_pkg::CIS_GIE_BIT] <= 1'b0;
      else if (state_q == cis_pkg::CIS_RET && cnt_q == cis_pkg::CIS_RET_LAST)
        status_q[cis_pkg::CIS_GIE_BIT] <= 1'b1;
      else if (instr_sei)
        status_q[cis_pkg::CIS_GIE_BIT] <= 1'b1;
      else if (wr_status)
        status_q <= reg_req.wdata;
    end
  end

  // One instruction must retire after set-enable or return
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      block_q <= 1'b0;
    else if (clk_en)
    begin
      if ((instr_sei && instr_boundary)
          || (state_q == cis_pkg::CIS_RET && cnt_q == cis_pkg::CIS_RET_LAST))
        block_q <= 1'b1;
      else if (instr_boundary)
        block_q <= 1'b0;
    end
  end

  // Software registers
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      general_irq_control_reg <= 8'h00;
      enable_q                <= 8'h00;
    end
    else if (clk_en && reg_req.wr)
    begin
      if (reg_req.addr == cis_pkg::CIS_A_GENERAL_IRQ_CONTROL_REG)
        general_irq_control_reg <= reg_req.wdata;
      if (reg_req.addr == cis_pkg::CIS_A_ENABLE)
        enable_q <= reg_req.wdata;
    end
  end

  // Stack pointer and stack traffic
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      sp_q     <= cis_pkg::CIS_SP_RST;
      mem_q    <= '0;
      ret_pc_q <= 13'h0000;
      pop_hi_q <= 8'h00;
    end
    else if (clk_en)
    begin
      mem_q <= '0;
      if (take)
        ret_pc_q <= program_counter;
      if (state_q == cis_pkg::CIS_ENTRY && cnt_q != cis_pkg::CIS_ENTRY_LAST)
      begin
        // Low byte first, stack grows downward
        mem_q.wr    <= 1'b1;
        mem_q.addr  <= sp_q;
        mem_q.wdata <= (cnt_q == 2'h0) ? ret_pc_q[7:0] : {3'h0, ret_pc_q[12:8]};
        sp_q        <= sp_q - cis_pkg::CIS_SP_STEP;
      end
      else if (return_from_irq_instr_go)
      begin
        mem_q.rd   <= 1'b1;
        mem_q.addr <= sp_q + cis_pkg::CIS_SP_STEP;
      end
      else if (state_q == cis_pkg::CIS_RET)
      begin
        if (cnt_q == 2'h0)
        begin
          mem_q.rd   <= 1'b1;
          mem_q.addr <= sp_q + 16'h0002;
        end
        if (cnt_q == 2'h1)
          pop_hi_q <= mem_rdata;
        if (cnt_q == cis_pkg::CIS_RET_LAST)
          sp_q <= sp_q + 16'h0002;
      end
      else if (reg_req.wr && reg_req.addr == cis_pkg::CIS_A_SPL)
        sp_q[7:0] <= reg_req.wdata;
      else if (reg_req.wr && reg_req.addr == cis_pkg::CIS_A_SPH)
        sp_q[15:8] <= reg_req.wdata;
    end
  end

  // Pipeline-facing outputs
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      busy_q         <= 1'b0;
      vec_valid_q    <= 1'b0;
      vec_addr_q     <= 13'h0000;
      sel_q          <= 8'h00;
      ack_q          <= 8'h00;
      resume_valid_q <= 1'b0;
      resume_pc_q    <= 13'h0000;
    end
    else if (clk_en)
    begin
      vec_valid_q    <= 1'b0;
      ack_q          <= 8'h00;
      resume_valid_q <= 1'b0;
      if (take)
      begin
        busy_q     <= 1'b1;
        sel_q      <= sel_oh;
        vec_addr_q <= sel_vec;
      end
      else if (return_from_irq_instr_go)
        busy_q <= 1'b1;
      if (state_q == cis_pkg::CIS_ENTRY && cnt_q == cis_pkg::CIS_ENTRY_LAST)
      begin
        vec_valid_q <= 1'b1;
        ack_q       <= sel_q;
      end
      if (state_q == cis_pkg::CIS_JUMP && cnt_q == cis_pkg::CIS_JUMP_LAST)
        busy_q <= 1'b0;
      if (state_q == cis_pkg::CIS_RET && cnt_q == cis_pkg::CIS_RET_LAST)
      begin
        busy_q         <= 1'b0;
        resume_valid_q <= 1'b1;
        resume_pc_q    <= {pop_hi_q[4:0], mem_rdata};
      end
    end
  end

  // Fuse sampled after reset release, never under it
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      reset_vec_q <= cis_pkg::CIS_APP_VEC;
    else if (clk_en)
      reset_vec_q <= boot_reset_fuse ? BOOT_START : cis_pkg::CIS_APP_VEC;
  end

  // Read port, data one cycle after the strobe
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      reg_rdata_q <= 8'h00;
    else if (clk_en)
    begin
      reg_rdata_q <= 8'h00;
      if (reg_req.rd)
      begin
        unique case (reg_req.addr)
          cis_pkg::CIS_A_STATUS: reg_rdata_q <= status_q;
          cis_pkg::CIS_A_GENERAL_IRQ_CONTROL_REG:   reg_rdata_q <= general_irq_control_reg;
          cis_pkg::CIS_A_ENABLE: reg_rdata_q <= enable_q;
          cis_pkg::CIS_A_FLAGS:  reg_rdata_q <= flag_q;
          cis_pkg::CIS_A_SPL:    reg_rdata_q <= sp_q[7:0];
          cis_pkg::CIS_A_SPH:    reg_rdata_q <= sp_q[15:8];
          default:               reg_rdata_q <= 8'h00;
        endcase
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset || !clk_en);

  sequence s_push;
    mem_q.wr ##1 mem_q.wr ##1 !mem_q.wr;
  endsequence

  a_take_enabled: assert property (take |-> gie && (sel_oh & enable_q) != 8'h00)
    else $error("interrupt taken while disabled");
  a_cli_blocks: assert property (instr_cli |-> !take)
    else $error("interrupt taken beside clear-enable");
  a_entry_gie: assert property (take |=> !gie)
    else $error("global enable not cleared on entry");
  a_entry_four: assert property (take && !sleeping |-> ##1 !vec_valid_q ##1 s_push ##0 vec_valid_q)
    else $error("vector not reached in four cycles");
  a_wake_eight: assert property (take && sleeping |-> ##8 vec_valid_q)
    else $error("wake entry not eight cycles");
  a_push_sp: assert property (take && !sleeping |-> ##3 sp_q == $past(sp_q, 3) - 16'h0002)
    else $error("stack pointer not lowered by two");
  a_jump_busy: assert property (vec_valid_q |-> busy_q [*3] ##1 !busy_q)
    else $error("jump window not three cycles");
  a_return_from_irq_instr_four: assert property (return_from_irq_instr_go |-> ##4 resume_valid_q && gie && block_q)
    else $error("return not done in four cycles");
  a_return_from_irq_instr_sp: assert property (return_from_irq_instr_go |-> ##4 sp_q == $past(sp_q, 4) + 16'h0002)
    else $error("stack pointer not raised by two");
  a_flag_hwclr: assert property (take && (sel_oh & evt_pulse) == 8'h00
                                 |=> (flag_q & $past(sel_oh)) == 8'h00)
    else $error("flag not cleared on vectoring");
  a_flag_w1c: assert property (wr_flags && evt_pulse == 8'h00
                               |=> (flag_q & $past(reg_req.wdata)) == 8'h00)
    else $error("write one did not clear flag");
  a_one_instr: assert property (block_q |-> !take)
    else $error("interrupt before one instruction");
  a_lock_sup: assert property (lock_sup |-> !take)
    else $error("interrupt inside locked section");
endmodule
`default_nettype wire

// ===== bench/cis_src_model.sv
// Model of the peripheral request sources and the stack memory
`default_nettype none
module cis_src_model (
  input  wire logic                  clk,
  input  wire cis_pkg::cis_mem_req_t mem_q,
  output logic [7:0]                 evt_pulse,
  output logic [7:0]                 lvl_req,
  output logic [7:0]                 mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:511];

  initial
  begin
    evt_pulse = 8'h00;
    lvl_req   = 8'h00;
    mem_rdata = 8'h00;
  end

  always @(posedge clk)
  begin
    if (mem_q.wr)
      mem[mem_q.addr[8:0]] <= mem_q.wdata;
    // Inverse outside the answer cycle, so stale data never passes for a match
    mem_rdata <= mem_q.rd ? mem[mem_q.addr[8:0]] : ~mem_rdata;
  end

  // One-cycle event on the masked sources
  task automatic pulse(input logic [7:0] m);
    @(posedge clk);
    evt_pulse <= m;
    @(posedge clk);
    evt_pulse <= 8'h00;
  endtask

  // Level condition held until changed again
  task automatic level(input logic [7:0] m);
    @(posedge clk);
    lvl_req <= m;
  endtask
endmodule
`default_nettype wire

// ===== bench/testbench.sv
// Self-checking bench for the interrupt sequencer
`default_nettype none
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin n_fail++; $display("MISMATCH %s exp %0h got %0h", n, e, a); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [12:0] BOOT = 13'h1C00;
  localparam logic [12:0] PCV  = 13'h1ABC;
  logic                  clk, reset, slp, fuse, lock_a, busy, vv, rv;
  logic [3:0]            ctl;
  logic                  en, lock_b;
  logic [12:0]           pcv;
  logic [7:0]            rdata, evt, lvl, mrd, ack;
  logic [12:0]           vaddr, rpc, rvec;
  cis_pkg::cis_reg_req_t req;
  cis_pkg::cis_mem_req_t mem_q;
  int                    n_fail = 0;
  int                    check_count = 0;
  int                    cyc = 0;

  cis_irq_seq #(.BOOT_START(BOOT), .LVL_MASK(8'h80)) uut (
    .clk(clk), .reset(reset), .clk_en(en), .reg_req(req), .reg_rdata_q(rdata),
    .evt_pulse(evt), .lvl_req(lvl), .instr_boundary(ctl[0]), .instr_sei(ctl[1]),
    .instr_cli(ctl[2]), .instr_return_from_irq_instr(ctl[3]), .sleeping(slp), .program_counter(pcv),
    .boot_reset_fuse(fuse), .app_boot_lock_setting(lock_a), .boot_section_lock_setting(lock_b),
    .mem_rdata(mrd), .mem_q(mem_q), .busy_q(busy), .vec_valid_q(vv), .vec_addr_q(vaddr),
    .ack_q(ack), .resume_valid_q(rv), .resume_pc_q(rpc), .reset_vec_q(rvec));

  cis_src_model src (.clk(clk), .mem_q(mem_q), .evt_pulse(evt), .lvl_req(lvl), .mem_rdata(mrd));

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge clk);
    req <= '0;
  endtask

  task automatic rchk(input logic [2:0] a, input logic [7:0] e, input string n);
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    req <= '0;
    #1 `CHK(n, e, rdata)
  endtask

  // One retiring instruction; busy is judged right after its edge
  task automatic ins(input logic s, input logic c, input logic r, input logic eb);
    @(posedge clk);
    ctl <= {r, c, s, 1'b1};
    @(posedge clk);
    ctl <= 4'h0;
    #1 `CHK("busy", eb, busy)
  endtask

  task automatic wait_idle();
    int n = 0;
    while (busy !== 1'b0 && n < 20)
    begin
      @(posedge clk);
      #1 n++;
    end
  endtask

  task automatic wait_vec(input int ne, input logic [12:0] ea, input logic [7:0] ek);
    int n = 0;
    while (vv !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      #1 n++;
    end
    if (ne > 0)
      `CHK("entry_latency", ne, n)
    `CHK("vec_valid", 1'b1, vv)
    `CHK("vector", ea, vaddr)
    `CHK("ack", ek, ack)
    wait_idle();
  endtask

  task automatic ret();
    int n = 0;
    ins(1'b0, 1'b0, 1'b1, 1'b1);
    while (rv !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      #1 n++;
    end
    `CHK("ret_latency", 3, n)
    `CHK("resume_pc", PCV, rpc)
    wait_idle();
    rchk(3'h0, 8'h80, "status_ret");
    rchk(3'h4, 8'h40, "spl_ret");
  endtask

  task automatic t_reset();
    rchk(3'h0, 8'h00, "status_rst");
    rchk(3'h6, 8'h00, "unmapped");
    rchk(3'h4, 8'h00, "spl_rst");
    `CHK("reset_vec", 13'h0000, rvec)
    fuse <= 1'b1;
    repeat (2) @(posedge clk);
    #1 `CHK("reset_vec_boot", BOOT, rvec)
    fuse <= 1'b0;
    // Frozen clock enable must swallow a write
    en <= 1'b0;
    wr(3'h2, 8'hFF);
    en <= 1'b1;
    rchk(3'h2, 8'h00, "frozen_enable");
    wr(3'h4, 8'h40);
    wr(3'h5, 8'h01);
  endtask

  task automatic t_entry();
    src.pulse(8'h22);
    rchk(3'h3, 8'h22, "flags_pending");
    wr(3'h2, 8'h22);
    ins(1'b0, 1'b0, 1'b0, 1'b0);
    wr(3'h2, 8'h00);
    wr(3'h0, 8'h80);
    ins(1'b0, 1'b0, 1'b0, 1'b0);
    ctl <= 4'h1;
    wr(3'h2, 8'h22);
    wait_vec(4, 13'h0004, 8'h02);
    ctl <= 4'h0;
    rchk(3'h0, 8'h00, "status_entry");
    rchk(3'h3, 8'h20, "flag_hw_clear");
    rchk(3'h4, 8'h3E, "spl_push");
    `CHK("push_lo", 8'hBC, src.mem[9'h140])
    `CHK("push_hi", 8'h1A, src.mem[9'h13F])
  endtask

  task automatic t_return();
    ret();
    ins(1'b0, 1'b0, 1'b0, 1'b0);
    ins(1'b0, 1'b0, 1'b0, 1'b1);
    wait_vec(0, 13'h000C, 8'h20);
    ret();
  endtask

  task automatic t_clear_cli();
    wr(3'h2, 8'h08);
    src.pulse(8'h08);
    wr(3'h3, 8'h00);
    rchk(3'h3, 8'h08, "w0_keeps");
    wr(3'h3, 8'h08);
    rchk(3'h3, 8'h00, "w1_clears");
    src.pulse(8'h08);
    repeat (3) @(posedge clk);
    #1 `CHK("no_boundary", 1'b0, busy)
    ins(1'b0, 1'b1, 1'b0, 1'b0);
    ins(1'b0, 1'b0, 1'b0, 1'b0);
    ins(1'b1, 1'b0, 1'b0, 1'b0);
    ins(1'b0, 1'b0, 1'b0, 1'b0);
    ins(1'b0, 1'b0, 1'b0, 1'b1);
    wait_vec(0, 13'h0008, 8'h08);
    ret();
  endtask

  task automatic t_vsel_lock();
    wr(3'h1, 8'h02);
    rchk(3'h1, 8'h02, "vsel");
    // Retire one instruction so only the lock can hold off the request
    ins(1'b0, 1'b0, 1'b0, 1'b0);
    lock_a <= 1'b1;
    src.pulse(8'h08);
    ins(1'b0, 1'b0, 1'b0, 1'b0);
    lock_a <= 1'b0;
    ins(1'b0, 1'b0, 1'b0, 1'b1);
    wait_vec(0, BOOT + 13'h0008, 8'h08);
    ret();
    wr(3'h1, 8'h00);
  endtask

  task automatic t_level();
    ins(1'b0, 1'b0, 1'b0, 1'b0);
    wr(3'h2, 8'h00);
    src.level(8'h80);
    src.level(8'h00);
    wr(3'h2, 8'h80);
    ins(1'b0, 1'b0, 1'b0, 1'b0);
    src.level(8'h80);
    ins(1'b0, 1'b0, 1'b0, 1'b1);
    wait_vec(0, 13'h0010, 8'h80);
    src.level(8'h00);
    ret();
  endtask

  task automatic t_sleep();
    // Clear the post-return block; sleep gives no boundary of its own
    ins(1'b0, 1'b0, 1'b0, 1'b0);
    wr(3'h2, 8'h00);
    slp <= 1'b1;
    src.pulse(8'h04);
    wr(3'h2, 8'h04);
    wait_vec(8, 13'h0006, 8'h04);
    slp <= 1'b0;
    ret();
  endtask

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Hang guard, well above the few hundred cycles the run needs
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      n_fail++;
      end_of_test();
    end
  end

  initial
  begin
    reset = 1'b1;
    req = '0;
    ctl = 4'h0;
    slp = 1'b0;
    fuse = 1'b0;
    lock_a = 1'b0;
    lock_b = 1'b0;
    en = 1'b1;
    pcv = PCV;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_entry();
    t_return();
    t_clear_cli();
    t_vsel_lock();
    t_level();
    t_sleep();
    end_of_test();
  end
endmodule
`default_nettype wire
